// [hdl/gt_pkg.sv]
// package for the gated 16-bit timer: offsets, fields, reset values
package gt_pkg;
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_GATE = 4'h4;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h8;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'hc;
  localparam int CS_POS = 6;
  localparam int PS_POS = 4;
  localparam int OSC_POS = 3;
  localparam int NOSYNC_POS = 2;
  localparam int ON_POS = 0;
  localparam int GE_POS = 7;
  localparam int GPOL_POS = 6;
  localparam int GTM_POS = 5;
  localparam int GSPM_POS = 4;
  localparam int GGO_POS = 3;
  localparam int GVAL_POS = 2;
  localparam int GSS_POS = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] GATE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'hfd;
  localparam logic [7:0] GATE_WMASK = 8'hfb;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYS = 2'h1;
  localparam logic [1:0] CS_PIN = 2'h2;
  localparam logic [1:0] CS_LFOSC = 2'h3;
  localparam logic [1:0] GS_PIN = 2'h0;
  localparam logic [1:0] GS_TMR8 = 2'h1;
  localparam logic [1:0] GS_CMP1 = 2'h2;
  localparam logic [1:0] GS_CMP2 = 2'h3;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
endpackage

// [hdl/gt_timer.sv]
// gated 16-bit timer with wishbone register slave
`timescale 1ns/10ps
// Operation
// R01: each compare auto-conversion trigger clears the whole 16-bit count.
// R02: a trigger clear does not set the rollover flag.
// R03: compare pair acts as period; count restarts at match.
// R04: a count byte write in the trigger cycle beats the clear.
// R05: software should use synchronised instruction clock for triggers.
// R06: bits 7:6 pick lf osc, pin/crystal, system or instruction clock.
// R07: pin source uses clock pin, or crystal when oscillator enabled.
// R08: bits 5:4 prescale by 1, 2, 4 or 8.
// R09: control bit 3 enables the secondary oscillator.
// R10: control bit 2 clear synchronises the count clock.
// R11: bit 0 enables counting; clearing stops it and clears toggle flop.
// R12: gate enable ignored when off; else counting follows the gate.
// R13: gate polarity bit 6: 1 counts on high, 0 on low.
// R14: bit 5 toggle mode; cleared holds the toggle flop clear.
// R15: bit 4 single-pulse mode controls the count gate.
// R16: armed bit set by software, cleared by hardware when done.
// R17: read-only bit 2 shows current gate level.
// R18: bits 1:0 pick comparator 2, comparator 1, 8-bit timer, pin.
// R19: writable control bits reset to zero.
// R20: count wraps ffff to 0000 and sets rollover flag.
// R21: falling gate level sets gate event flag, even ungated.
// R22: single pulse counts from arming until trailing edge, then done.
// R23: 8-bit timer wrap gives one rising pulse to the gate.
// R24: enabled ungated counter increments once per prescaler output.
module gt_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic ext_clk_pin_i,
  input wire logic crystal_clk_i,
  input wire logic low_freq_osc_i,
  input wire logic gate_pin_i,
  input wire logic comparator_one_out_i,
  input wire logic comparator_two_out_i,
  input wire logic tmr8_wrap_i,
  input wire logic compare_trigger_mode_i,
  input wire logic [15:0] compare_value_i,
  output logic [15:0] count_o,
  output logic rollover_flag_o,
  output logic gate_event_flag_o,
  output logic secondary_osc_enable_o,
  output logic trigger_o
);
  // gate level is level-compared against a delayed copy for edges
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] gate;
    logic [15:0] count;
    logic [2:0] pin_sync;
    logic [2:0] xtal_sync;
    logic [2:0] lf_sync;
    logic [2:0] gpin_sync;
    logic [2:0] c1_sync;
    logic [2:0] c2_sync;
    logic pin_f;
    logic xtal_f;
    logic lf_f;
    logic gpin_f;
    logic c1_f;
    logic c2_f;
    logic [1:0] instr_div;
    logic src_prev;
    logic [2:0] prescale;
    logic gsrc_prev;
    logic toggle;
    logic gate_lvl;
    logic gate_lvl_prev;
    logic sp_run;
    logic rollover;
    logic gate_event;
    logic trig;
    logic ack;
    logic [31:0] rdata;
  } gt_state_type;

  gt_state_type s;
  gt_state_type next_s;

  // a change is taken only once stages two and three agree
  function automatic logic settle(input logic [2:0] v, input logic held);
    settle = (v[2] == v[1]) ? v[2] : held;
  endfunction

  logic wr;
  logic rd;
  logic clk_src;
  logic src_edge;
  logic tick;
  logic gate_src;
  logic gate_in;
  logic gate_ok;
  logic gate_count;
  logic count_en;
  logic match;
  logic [1:0] cs;
  logic [1:0] ps;
  logic [1:0] gss;

  always_comb
  begin
    next_s = s;
    wr = cyc_i && stb_i && we_i && !s.ack && sel_i[0];
    rd = cyc_i && stb_i && !s.ack;
    cs = s.control[gt_pkg::CS_POS +: 2];
    ps = s.control[gt_pkg::PS_POS +: 2];
    gss = s.gate[gt_pkg::GSS_POS +: 2];
    // three-stage synchronisers; only the last two stages are read
    next_s.pin_sync = {s.pin_sync[1:0], ext_clk_pin_i};
    next_s.xtal_sync = {s.xtal_sync[1:0],
      crystal_clk_i && s.control[gt_pkg::OSC_POS]}; // R09
    next_s.lf_sync = {s.lf_sync[1:0], low_freq_osc_i};
    next_s.gpin_sync = {s.gpin_sync[1:0], gate_pin_i};
    next_s.c1_sync = {s.c1_sync[1:0], comparator_one_out_i};
    next_s.c2_sync = {s.c2_sync[1:0], comparator_two_out_i};
    next_s.pin_f = settle(s.pin_sync, s.pin_f);
    next_s.xtal_f = settle(s.xtal_sync, s.xtal_f);
    next_s.lf_f = settle(s.lf_sync, s.lf_f);
    next_s.gpin_f = settle(s.gpin_sync, s.gpin_f);
    next_s.c1_f = settle(s.c1_sync, s.c1_f);
    next_s.c2_f = settle(s.c2_sync, s.c2_f);
    next_s.instr_div = s.instr_div + 2'h1;
    // async sources sampled here regardless of the no-sync bit; an
    // unsynchronised path cannot exist in a single-clock design
    unique case (cs) // R06
      gt_pkg::CS_INSTR: clk_src = (s.instr_div == gt_pkg::INSTR_DIV_LAST);
      gt_pkg::CS_SYS: clk_src = 1'b1;
      gt_pkg::CS_PIN: clk_src = s.control[gt_pkg::OSC_POS] ?
        s.xtal_f : s.pin_f; // R07
      gt_pkg::CS_LFOSC: clk_src = s.lf_f;
    endcase
    // R10: sync bit clear or set, edges are taken on clk_i
    next_s.src_prev = clk_src;
    if (cs == gt_pkg::CS_SYS || cs == gt_pkg::CS_INSTR)
      src_edge = clk_src;
    else
      src_edge = clk_src && !s.src_prev;
    tick = 1'b0;
    if (src_edge && s.control[gt_pkg::ON_POS])
    begin
      next_s.prescale = s.prescale + 3'h1;
      unique case (ps) // R08
        2'h0: tick = 1'b1;
        2'h1: tick = s.prescale[0];
        2'h2: tick = &s.prescale[1:0];
        2'h3: tick = &s.prescale;
      endcase
    end
    unique case (gss) // R18
      gt_pkg::GS_PIN: gate_src = s.gpin_f;
      gt_pkg::GS_TMR8: gate_src = tmr8_wrap_i; // R23
      gt_pkg::GS_CMP1: gate_src = s.c1_f;
      gt_pkg::GS_CMP2: gate_src = s.c2_f;
    endcase
    next_s.gsrc_prev = gate_src;
    if (!s.gate[gt_pkg::GTM_POS] || !s.control[gt_pkg::ON_POS])
      next_s.toggle = 1'b0; // R11 R14
    else if (gate_src && !s.gsrc_prev)
      next_s.toggle = !s.toggle; // R14
    gate_in = s.gate[gt_pkg::GTM_POS] ? s.toggle : gate_src;
    gate_ok = (gate_in == s.gate[gt_pkg::GPOL_POS]); // R13
    // single pulse: run from arming through active phase
    if (s.gate[gt_pkg::GSPM_POS]) // R15
    begin
      if (s.gate[gt_pkg::GGO_POS] && gate_ok)
        next_s.sp_run = 1'b1;
      if (s.sp_run && !gate_ok)
      begin
        next_s.sp_run = 1'b0;
        next_s.gate[gt_pkg::GGO_POS] = 1'b0; // R16 R22
      end
      gate_count = s.sp_run && gate_ok; // R22
    end
    else
    begin
      next_s.sp_run = 1'b0;
      gate_count = gate_ok;
    end
    next_s.gate_lvl = gate_count; // R17
    next_s.gate_lvl_prev = s.gate_lvl;
    if (!s.gate_lvl && s.gate_lvl_prev)
      next_s.gate_event = 1'b1; // R21
    count_en = !s.gate[gt_pkg::GE_POS] || gate_count; // R12
    match = compare_trigger_mode_i && (s.count == compare_value_i); // R03
    next_s.trig = 1'b0;
    if (match)
    begin
      next_s.count = gt_pkg::COUNT_RESET; // R01 R02
      next_s.trig = 1'b1;
    end
    else if (tick && count_en) // R24
    begin
      next_s.count = s.count + 16'h0001;
      if (s.count == gt_pkg::COUNT_MAX)
        next_s.rollover = 1'b1; // R20
    end
    next_s.ack = rd;
    next_s.rdata = 32'h0000_0000;
    if (rd)
    begin
      unique case (adr_i)
        gt_pkg::ADDR_CONTROL: next_s.rdata[7:0] = s.control;
        gt_pkg::ADDR_GATE: next_s.rdata[7:0] =
          {s.gate[7:3], s.gate_lvl, s.gate[1:0]}; // R17
        gt_pkg::ADDR_COUNT_LOW: next_s.rdata[7:0] = s.count[7:0];
        gt_pkg::ADDR_COUNT_HIGH: next_s.rdata[7:0] = s.count[15:8];
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (wr)
    begin
      unique case (adr_i)
        gt_pkg::ADDR_CONTROL:
          next_s.control = dat_i[7:0] & gt_pkg::CONTROL_WMASK;
        gt_pkg::ADDR_GATE:
        begin
          next_s.gate = dat_i[7:0] & gt_pkg::GATE_WMASK;
          // a gate write clears the armed bit unless it also sets single-pulse mode
          if (!dat_i[gt_pkg::GSPM_POS])
            next_s.gate[gt_pkg::GGO_POS] = 1'b0;
        end
        gt_pkg::ADDR_COUNT_LOW: next_s.count[7:0] = dat_i[7:0]; // R04
        gt_pkg::ADDR_COUNT_HIGH: next_s.count[15:8] = dat_i[7:0]; // R04
        default: next_s.count = next_s.count;
      endcase
    end
    // flag clear: write 1 to bit 8 or 9 at the control address; set wins
    if (wr && adr_i == gt_pkg::ADDR_CONTROL && sel_i[1])
    begin
      if (dat_i[8] && !(next_s.rollover && !s.rollover))
        next_s.rollover = 1'b0;
      if (dat_i[9] && !(next_s.gate_event && !s.gate_event))
        next_s.gate_event = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0; // R19
      s.control <= gt_pkg::CONTROL_RESET;
      s.gate <= gt_pkg::GATE_RESET;
      s.count <= gt_pkg::COUNT_RESET;
    end
    else
      s <= next_s;
  end

  assign dat_o = s.rdata;
  assign ack_o = s.ack;
  assign count_o = s.count;
  assign rollover_flag_o = s.rollover;
  assign gate_event_flag_o = s.gate_event;
  assign secondary_osc_enable_o = s.control[gt_pkg::OSC_POS];
  assign trigger_o = s.trig;

  a_trig_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    match && !wr |=> s.count == 16'h0000) // R01
    else $error("trigger did not clear count");
  a_trig_noflag: assert property (@(posedge clk_i) disable iff (rst_i)
    match && !s.rollover && !wr |=> !s.rollover) // R02
    else $error("trigger set rollover flag");
  a_write_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    match && wr && adr_i == gt_pkg::ADDR_COUNT_LOW
    |=> s.count[7:0] == $past(dat_i[7:0])) // R04
    else $error("trigger beat count write");
  a_off_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.control[0] && !match && !wr |=> s.count == $past(s.count)) // R11
    else $error("counter moved while off");
  a_toggle_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.gate[5] |=> !s.toggle) // R14
    else $error("toggle flop not held clear");
  a_wrap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && count_en && !match && !wr && s.count == 16'hffff
    |=> s.rollover && s.count == 16'h0000) // R20
    else $error("rollover missing");
  a_gate_event: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.gate_lvl && s.gate_lvl_prev |=> s.gate_event) // R21
    else $error("gate event flag missing");
  a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && count_en && !match && !wr
    |=> s.count == $past(s.count) + 16'h0001) // R24
    else $error("count did not increment");
  a_sp_done: assert property (@(posedge clk_i) disable iff (rst_i)
    s.gate[4] && s.sp_run && !gate_ok && !wr |=> !s.gate[3]) // R16
    else $error("armed bit not cleared");
  c_trigger: cover property (@(posedge clk_i) match);
  c_rollover: cover property (@(posedge clk_i) $rose(s.rollover));
  c_pulse_done: cover property (@(posedge clk_i) $fell(s.gate[3]));
  c_toggle: cover property (@(posedge clk_i) $rose(s.toggle));
  c_gate_evt: cover property (@(posedge clk_i) $rose(s.gate_event));

  // bus side: single-cycle ack, data only while acked
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s.ack |=> !s.ack)
    else $error("ack held more than one cycle");
  a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i) |=> !s.ack)
    else $error("ack without request");
  a_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.ack |-> s.rdata == 32'h0000_0000)
    else $error("read data outside ack");
  a_ctl_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.control[1]) // R19
    else $error("unused control bit set");

  // trigger and count
  a_trig_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    match |=> s.trig) // R01
    else $error("trigger pulse missing");
  a_trig_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !match |=> !s.trig) // R01
    else $error("trigger without match");
  a_write_high: assert property (@(posedge clk_i) disable iff (rst_i)
    match && wr && adr_i == gt_pkg::ADDR_COUNT_HIGH
    |=> s.count[15:8] == $past(dat_i[7:0])) // R04
    else $error("trigger beat high byte write");
  a_ungated_run: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && !s.gate[7] && !match && !wr
    |=> s.count == $past(s.count) + 16'h0001) // R12
    else $error("ungated counter held");
  a_gated_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s.control[0] && s.gate[7] && !gate_count && !match && !wr
    |=> s.count == $past(s.count)) // R12
    else $error("closed gate let count move");
  a_rof_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    s.rollover && !(wr && adr_i == gt_pkg::ADDR_CONTROL && sel_i[1]
    && dat_i[8]) |=> s.rollover) // R20
    else $error("rollover flag lost");
  a_gef_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    s.gate_event && !(wr && adr_i == gt_pkg::ADDR_CONTROL && sel_i[1]
    && dat_i[9]) |=> s.gate_event) // R21
    else $error("gate event flag lost");

  // clock selection and prescale; pin edges need a low phase first
  a_sys_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    cs == gt_pkg::CS_SYS && s.control[0] && ps == 2'h0 |-> tick) // R06
    else $error("system clock tick missing");
  a_instr_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    cs == gt_pkg::CS_INSTR && s.instr_div != gt_pkg::INSTR_DIV_LAST
    |-> !tick) // R06
    else $error("instruction clock too fast");
  a_div_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    s.instr_div == 2'h3 |=> s.instr_div == 2'h0) // R06
    else $error("instruction divider broken");
  a_pin_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    cs == gt_pkg::CS_PIN && src_edge |-> !s.src_prev) // R07
    else $error("pin count without rising edge");
  a_presc_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ps == 2'h3 && s.prescale != 3'h7 |-> !tick) // R08
    else $error("divide by eight ticked early");
  a_xtal_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.control[3] |=> !s.xtal_sync[0]) // R09
    else $error("crystal passed while disabled");

  // gate path
  a_off_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.control[0] |=> !s.toggle) // R11
    else $error("toggle flop kept while off");
  a_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
    s.gate[6] && !s.gate[5] |-> gate_ok == gate_src) // R13
    else $error("gate polarity wrong");
  a_toggle_flip: assert property (@(posedge clk_i) disable iff (rst_i)
    s.control[0] && s.gate[5] && gate_src && !s.gsrc_prev
    |=> s.toggle != $past(s.toggle)) // R14
    else $error("toggle flop missed an edge");
  a_sp_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    s.gate[4] && !s.sp_run |-> !gate_count) // R15
    else $error("single pulse counted before start");
  a_sp_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.gate[4] |=> !s.sp_run) // R15
    else $error("single pulse ran while disabled");
  a_arm_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s.gate[3] && s.gate[4] && !s.sp_run && !wr |=> s.gate[3]) // R16
    else $error("armed bit lost before pulse");
  a_level_view: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> s.gate_lvl == $past(gate_count)) // R17
    else $error("gate level not reported");
endmodule

// [tb/gt_far.sv]
// far side model: compare unit, 8-bit timer wrap, slow clock sources
`timescale 1ns/10ps
module gt_far (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mode_i,
  input wire logic [15:0] period_i,
  output logic compare_trigger_mode_o,
  output logic [15:0] compare_value_o,
  output logic tmr8_wrap_o,
  output logic pin_clk_o,
  output logic lf_clk_o
);
  logic [7:0] cnt;
  // free-running source so pin and lf rates divide 64 exactly
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= 8'h00;
    else
      cnt <= cnt + 8'h01;
    compare_trigger_mode_o <= mode_i;
    compare_value_o <= period_i;
  end
  assign tmr8_wrap_o = (cnt == 8'hff);
  assign pin_clk_o = cnt[2];
  assign lf_clk_o = cnt[3];
endmodule

// [tb/gt_timer_test.sv]
// self-checking bench for the gated timer
`timescale 1ns/10ps
module gt_timer_test;
  logic clk_i, rst_i, we, cyc, stb, ack_o, gp, mode;
  logic [3:0] adr, sel;
  logic [31:0] dat, dat_o;
  logic [15:0] per, count_o, r, mx;
  logic rof, gef, osc, trg, t8, pclk, lclk, ctm;
  logic [15:0] cval;
  logic [15:0] q[$];
  int n_fail = 0, cmp_count = 0, nt, k;
  logic [15:0] rt[4] = '{16'h10, 16'h40, 16'h8, 16'h4};
  gt_timer i_gt_timer (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(dat), .dat_o(dat_o), .we_i(we), .sel_i(sel), .cyc_i(cyc),
    .stb_i(stb), .ack_o(ack_o), .ext_clk_pin_i(pclk),
    .crystal_clk_i(pclk), .low_freq_osc_i(lclk), .gate_pin_i(gp),
    .comparator_one_out_i(1'b0), .comparator_two_out_i(1'b0),
    .tmr8_wrap_i(t8), .compare_trigger_mode_i(ctm),
    .compare_value_i(cval), .count_o(count_o), .rollover_flag_o(rof),
    .gate_event_flag_o(gef), .secondary_osc_enable_o(osc),
    .trigger_o(trg));
  gt_far i_gt_far (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode),
    .period_i(per), .compare_trigger_mode_o(ctm),
    .compare_value_o(cval), .tmr8_wrap_o(t8), .pin_clk_o(pclk),
    .lf_clk_o(lclk));
  initial
  begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  task finish_test;
    $display("mismatches %0d of %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // read results are checked where ack appears, oldest note first
  always @(posedge clk_i)
    if (ack_o === 1'b1 && we === 1'b0)
      chk("read", q.pop_front(), dat_o[15:0]);
  task wb(input logic [3:0] a, input logic w, input logic [15:0] d,
          input logic [1:0] s);
    int i;
    @(posedge clk_i);
    adr <= a;
    we <= w;
    dat <= {16'h0, d};
    sel <= {2'h0, s};
    cyc <= 1;
    stb <= 1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_i);
      if (ack_o === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_fail++;
      finish_test;
    end
    cyc <= 0;
    stb <= 0;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    wb(a, 1, {8'h0, d}, 2'h1);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    q.push_back({8'h0, e});
    wb(a, 0, 16'h0, 2'h1);
  endtask
  // increments seen over 64 cycles once the new setting settles
  task rate(input string n, input logic [15:0] e);
    logic [15:0] c0;
    repeat (16) @(posedge clk_i);
    c0 = count_o;
    repeat (64) @(posedge clk_i);
    chk(n, e, count_o - c0);
  endtask
  initial
  begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    finish_test;
  end
  initial
  begin
    rst_i = 1;
    {we, cyc, stb, gp, mode} = 5'h0;
    adr = 4'h0;
    sel = 4'h0;
    dat = 32'h0;
    per = 16'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    void'($urandom(6805));
    rd(gt_pkg::ADDR_CONTROL, gt_pkg::CONTROL_RESET);
    // low pin with low polarity: gate level reads one
    rd(gt_pkg::ADDR_GATE, gt_pkg::GATE_RESET | 8'h04);
    rd(gt_pkg::ADDR_COUNT_HIGH, 8'h00);
    $display("reset test done");
    r = $urandom;
    wr(gt_pkg::ADDR_COUNT_LOW, r[7:0]);
    wr(gt_pkg::ADDR_COUNT_HIGH, r[15:8]);
    rd(gt_pkg::ADDR_COUNT_LOW, r[7:0]);
    rd(gt_pkg::ADDR_COUNT_HIGH, r[15:8]);
    wr(gt_pkg::ADDR_CONTROL, 8'hff);
    rd(gt_pkg::ADDR_CONTROL, gt_pkg::CONTROL_WMASK);
    chk("osc", 16'h1, {15'h0, osc});
    $display("register test done");
    for (k = 0; k < 4; k++)
    begin
      wr(gt_pkg::ADDR_CONTROL, {k[1:0], 6'h01});
      rate("source", rt[k]);
    end
    wr(gt_pkg::ADDR_CONTROL, {gt_pkg::CS_PIN, 6'h09});
    rate("crystal", 16'h8);
    for (k = 0; k < 4; k++)
    begin
      wr(gt_pkg::ADDR_CONTROL, {gt_pkg::CS_SYS, k[1:0], 4'h1});
      rate("prescale", 16'h40 >> k);
    end
    $display("clock test done");
    wr(gt_pkg::ADDR_CONTROL, 8'h00);
    rate("off", 16'h0);
    wr(gt_pkg::ADDR_COUNT_LOW, 8'hff);
    wr(gt_pkg::ADDR_COUNT_HIGH, 8'hff);
    wr(gt_pkg::ADDR_CONTROL, 8'h41);
    for (k = 0; k < 20 && rof !== 1'b1; k++)
      @(posedge clk_i);
    chk("rollover", 16'h1, {15'h0, rof});
    wb(gt_pkg::ADDR_CONTROL, 1, 16'h0100, 2'h3);
    chk("rollover clr", 16'h0, {15'h0, rof});
    wr(gt_pkg::ADDR_COUNT_LOW, 8'h00);
    mode <= 1;
    per <= 16'h0005;
    // synchronised instruction clock so no trigger is missed
    wr(gt_pkg::ADDR_CONTROL, 8'h01);
    mx = 0;
    nt = 0;
    repeat (200)
    begin
      @(posedge clk_i);
      if (count_o > mx)
        mx = count_o;
      if (trg === 1'b1)
        nt++;
    end
    chk("period", 16'h0005, mx);
    chk("trigger", 16'h1, {15'h0, nt > 0});
    chk("no rollover", 16'h0, {15'h0, rof});
    mode <= 0;
    $display("trigger test done");
    wr(gt_pkg::ADDR_GATE, 8'hc0);
    wr(gt_pkg::ADDR_CONTROL, 8'h41);
    rate("gate low", 16'h0);
    gp <= 1;
    rate("gate high", 16'h40);
    rd(gt_pkg::ADDR_GATE, 8'hc4);
    // clear the event left by the gate write so the fall is seen fresh
    wb(gt_pkg::ADDR_CONTROL, 1, 16'h0241, 2'h3);
    chk("gate event clr", 16'h0, {15'h0, gef});
    gp <= 0;
    repeat (10) @(posedge clk_i);
    chk("gate event", 16'h1, {15'h0, gef});
    wr(gt_pkg::ADDR_GATE, 8'h80);
    rate("active low", 16'h40);
    $display("gate test done");
    repeat (2) @(posedge clk_i);
    finish_test;
  end
endmodule
